/* design/channel_status_subcode_decoder.sv */
// Channel-status and user-data section of a two-channel digital audio receiver.
// Assumes decoded word bits arrive on core_clk with a one-cycle word strobe;
// biphase_in is the raw line and is synchronised here.
`timescale 1ns/10ps
`include "subcode_defines.svh"
module channel_status_subcode_decoder (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic biphase_in,
   input wire logic word_strobe,
   input wire logic word_left,
   input wire logic block_start,
   input wire logic word_v,
   input wire logic word_u,
   input wire logic word_c,
   input wire logic word_p,
   output logic user_data_out,
   output logic user_clock_out,
   output logic preemphasis_level_out,
   output logic control_bits_out
);
   import subcode_pkg::*;
   word_link_if wl ();

   serial_word_sender serial_word_sender_inst (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .wl(wl)
   );

   // Line activity
   logic bi_s1, bi_s2, bi_s3;
   logic [5:0] absent_cnt, next_absent_cnt;
   logic absent, next_absent;
   // Channel status
   logic [16:1] cs, next_cs;
   logic [4:0] cs_idx, next_cs_idx;
   logic cs_copy, next_cs_copy, cs_pre, next_cs_pre, two_ch, next_two_ch;
   out_mode_type out_mode, next_out_mode;
   // Subcode assembly
   logic [4:0] zero_run, next_zero_run;
   logic synced, next_synced, collecting, next_collecting;
   logic [2:0] bit_cnt, next_bit_cnt;
   logic [6:0] qw, next_qw, byte_hold, next_byte_hold;
   logic first_byte, next_first_byte, first_hold, next_first_hold;
   logic byte_ready, next_byte_ready;
   logic [15:0] crc, next_crc, qlast, next_qlast;
   logic [6:0] q_cnt, next_q_cnt;
   logic crc_ok, next_crc_ok;
   logic [1:0] pend, next_pend;
   logic start, next_start;
   word_type word, next_word;
   // Control bits and pins
   logic [3:0] cdb_bits, next_cdb_bits;
   logic [7:0] cdb_cnt, next_cdb_cnt;
   logic cdb_run;
   logic [1:0] cdb_idx;
   logic next_udo, next_ucl, next_pre, next_cdb;

   // Line activity watchdog; bi_s1 feeds only bi_s2
   always_comb begin
      next_absent_cnt = absent_cnt;
      next_absent = absent;
      if (bi_s2 != bi_s3) begin
         next_absent_cnt = 6'h00;
         next_absent = 1'b0;
      end else if (absent_cnt == `ABSENT_CLKS - 6'h01) begin
         next_absent = 1'b1;
      end else begin
         next_absent_cnt = absent_cnt + 6'h01;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         bi_s1 <= 1'b0;
         bi_s2 <= 1'b0;
         bi_s3 <= 1'b0;
         absent_cnt <= 6'h00;
         absent <= 1'b0;
      end else begin
         bi_s1 <= biphase_in;
         bi_s2 <= bi_s1;
         bi_s3 <= bi_s2;
         absent_cnt <= next_absent_cnt;
         absent <= next_absent;
      end
   end

   // Channel-status block capture from the left words; choice held for a block
   always_comb begin
      logic [4:0] idx;
      idx = block_start ? 5'h01 : cs_idx;
      next_cs = cs;
      next_cs_idx = cs_idx;
      next_cs_copy = cs_copy;
      next_cs_pre = cs_pre;
      next_two_ch = two_ch;
      next_out_mode = out_mode;
      if (word_strobe && word_left && (idx <= `CS_LAST_BIT)) begin
         next_cs[idx] = word_c;
         next_cs_idx = idx + 5'h01;
         if (idx == `CS_LAST_BIT) begin
            next_cs_copy = cs[`CS_COPY_BIT];
            next_cs_pre = cs[`CS_PRE_BIT];
            next_two_ch = (cs[2:1] == `CTL_TWO_CH);
            if (cs[8:7] != `MODE_ZERO) begin
               next_out_mode = OUT_SILENT;
            end else if ({cs[9], cs[10], cs[11], cs[12], cs[13], cs[14], cs[15], word_c} == `CAT_CD) begin
               next_out_mode = OUT_SUBCODE;
            end else if (cs[2:1] == `CTL_TWO_CH) begin
               next_out_mode = OUT_FLAGS;
            end else begin
               next_out_mode = OUT_SILENT;
            end
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cs <= 16'h0000;
         cs_idx <= 5'h11;
         cs_copy <= 1'b0;
         cs_pre <= 1'b0;
         two_ch <= 1'b0;
         out_mode <= OUT_SILENT;
      end else begin
         cs <= next_cs;
         cs_idx <= next_cs_idx;
         cs_copy <= next_cs_copy;
         cs_pre <= next_cs_pre;
         two_ch <= next_two_ch;
         out_mode <= next_out_mode;
      end
   end

   // Subcode assembly: start bit, then Q..W; the first 80 Q bits run the CRC
   always_comb begin
      next_zero_run = zero_run;
      next_synced = synced;
      next_collecting = collecting;
      next_bit_cnt = bit_cnt;
      next_qw = qw;
      next_first_byte = first_byte;
      next_byte_ready = 1'b0;
      next_byte_hold = byte_hold;
      next_first_hold = first_hold;
      next_crc = crc;
      next_qlast = qlast;
      next_q_cnt = q_cnt;
      next_crc_ok = crc_ok;
      if (word_strobe) begin
         next_zero_run = word_u ? 5'h00 : ((zero_run == `ZERO_RUN_MIN) ? zero_run : zero_run + 5'h01);
         if (collecting) begin
            next_qw = {word_u, qw[6:1]};
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == 3'h0) begin
               next_qlast = {qlast[14:0], word_u};
               if (q_cnt < `Q_DATA_BITS) begin
                  next_crc = {crc[14:0], 1'b0} ^ ((word_u ^ crc[15]) ? `CRC_POLY : 16'h0000);
               end
               if (q_cnt != `Q_TOTAL_BITS) begin
                  next_q_cnt = q_cnt + 7'h01;
               end
            end
            if (bit_cnt == `SUB_BITS - 3'h1) begin
               next_collecting = 1'b0;
               next_byte_ready = 1'b1; // Whole byte in hand
               next_byte_hold = {word_u, qw[6:1]};
               next_first_hold = first_byte;
               next_first_byte = 1'b0;
            end
         end else if (word_u && (zero_run == `ZERO_RUN_MIN)) begin
            // New subcode frame: judge the previous Q block
            next_synced = 1'b1;
            next_collecting = 1'b1;
            next_bit_cnt = 3'h0;
            next_first_byte = 1'b1;
            next_crc_ok = (q_cnt == `Q_TOTAL_BITS) && (crc == ~qlast);
            next_crc = 16'h0000;
            next_qlast = 16'h0000;
            next_q_cnt = 7'h00;
         end else if (word_u && synced) begin
            next_collecting = 1'b1;
            next_bit_cnt = 3'h0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         zero_run <= 5'h00;
         synced <= 1'b0;
         collecting <= 1'b0;
         bit_cnt <= 3'h0;
         qw <= 7'h00;
         first_byte <= 1'b0;
         byte_ready <= 1'b0;
         byte_hold <= 7'h00;
         first_hold <= 1'b0;
         crc <= 16'h0000;
         qlast <= 16'h0000;
         q_cnt <= 7'h00;
         crc_ok <= 1'b0;
      end else begin
         zero_run <= next_zero_run;
         synced <= next_synced;
         collecting <= next_collecting;
         bit_cnt <= next_bit_cnt;
         qw <= next_qw;
         first_byte <= next_first_byte;
         byte_ready <= next_byte_ready;
         byte_hold <= next_byte_hold;
         first_hold <= next_first_hold;
         crc <= next_crc;
         qlast <= next_qlast;
         q_cnt <= next_q_cnt;
         crc_ok <= next_crc_ok;
      end
   end

   // Word issue; a byte arriving mid-series replaces the rest of it
   always_comb begin
      next_pend = pend;
      next_start = 1'b0;
      next_word = word;
      if (byte_ready) begin
         next_pend = first_hold ? `SERIES_FIRST : 2'h1;
      end else if ((pend != 2'h0) && !wl.busy && !start && (out_mode == OUT_SUBCODE)) begin
         next_start = 1'b1;
         next_pend = pend - 2'h1;
         if (first_hold && (pend == 2'h3)) begin
            next_word = {2'b00, byte_hold[4], byte_hold[3], byte_hold[2], byte_hold[1], byte_hold[0], 3'b100};
         end else if (first_hold && (pend == 2'h2)) begin
            next_word = {crc_ok, 1'b0, byte_hold[5], byte_hold[4], byte_hold[3], byte_hold[2],
                         byte_hold[1], byte_hold[0], 2'b10};
         end else begin
            next_word = {2'b00, byte_hold[6], byte_hold[5], byte_hold[4], byte_hold[3], byte_hold[2],
                         byte_hold[1], byte_hold[0], 1'b1};
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pend <= 2'h0;
         start <= 1'b0;
         word <= 10'h000;
      end else begin
         pend <= next_pend;
         start <= next_start;
         word <= next_word;
      end
   end

   assign wl.start = start;
   assign wl.word = word;

   // Control-bit serialiser and pin registers; every pin leaves a flop
   assign cdb_run = (cdb_cnt < `CDB_TOTAL_CLKS);
   assign cdb_idx = 2'(cdb_cnt / `CDB_HOLD_CLKS);

   always_comb begin
      next_cdb_bits = cdb_bits;
      next_cdb_cnt = cdb_cnt;
      if (word_strobe) begin
         next_cdb_bits = {word_p, word_c, word_u, word_v}; // V leaves first
         next_cdb_cnt = 8'h00;
      end else if (cdb_run) begin
         next_cdb_cnt = cdb_cnt + 8'h01;
      end
      next_udo = 1'b0;
      next_ucl = 1'b0;
      next_pre = two_ch & cs_pre;
      next_cdb = cdb_run & cdb_bits[cdb_idx];
      case (out_mode)
         OUT_SUBCODE: begin
            next_udo = wl.sdata;
            next_ucl = wl.sclk;
         end
         OUT_FLAGS: begin
            next_udo = cs_pre;
            next_ucl = cs_copy;
         end
         default: begin
            next_udo = 1'b0;
            next_ucl = 1'b0;
         end
      endcase
      if (absent) begin
         next_udo = 1'b0;
         next_ucl = 1'b1;
         next_pre = 1'b0;
         next_cdb = 1'b0;
      end
   end

   // Rising-edge only pin updates
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cdb_bits <= 4'h0;
         cdb_cnt <= `CDB_TOTAL_CLKS;
         user_data_out <= 1'b0;
         user_clock_out <= 1'b0;
         preemphasis_level_out <= 1'b0;
         control_bits_out <= 1'b0;
      end else begin
         cdb_bits <= next_cdb_bits;
         cdb_cnt <= next_cdb_cnt;
         user_data_out <= next_udo;
         user_clock_out <= next_ucl;
         preemphasis_level_out <= next_pre;
         control_bits_out <= next_cdb;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   property p_cd_only;
      start |-> out_mode == OUT_SUBCODE;
   endproperty
   a_cd_only: assert property (p_cd_only) else $error("word sent outside subcode mode");

   property p_after_sync;
      byte_ready |-> synced;
   endproperty
   a_after_sync: assert property (p_after_sync) else $error("byte assembled before zero run");

   property p_three_series;
      byte_ready && first_hold |=> pend == 2'h3;
   endproperty
   a_three_series: assert property (p_three_series) else $error("first word not queued three times");

   property p_crc_slot;
      start && first_hold && $past(pend) == 2'h2 |-> word[9] == crc_ok && word[1:0] == 2'b10;
   endproperty
   a_crc_slot: assert property (p_crc_slot) else $error("second repetition lacks CRC flag");

   property p_flags;
      !absent && out_mode == OUT_FLAGS |=> user_data_out == $past(cs_pre) && user_clock_out == $past(cs_copy);
   endproperty
   a_flags: assert property (p_flags) else $error("flag pins do not follow channel status");

   property p_pre_level;
      !absent && two_ch |=> preemphasis_level_out == $past(cs_pre);
   endproperty
   a_pre_level: assert property (p_pre_level) else $error("pre-emphasis level wrong");

   property p_cdb_first;
      word_strobe && !absent ##1 !word_strobe && !absent |=> control_bits_out == $past(word_v, 2);
   endproperty
   a_cdb_first: assert property (p_cdb_first) else $error("control output does not open with V");

   property p_cdb_hold;
      cdb_run && cdb_cnt[4:0] != 5'h00 && !absent && !$past(absent) && $past(cdb_run) |=> $stable(control_bits_out);
   endproperty
   a_cdb_hold: assert property (p_cdb_hold) else $error("control bit left early");

   property p_absent;
      absent |=> user_clock_out && !user_data_out && !preemphasis_level_out && !control_bits_out;
   endproperty
   a_absent: assert property (p_absent) else $error("silent line levels wrong");

   c_subcode_word: cover property (start && out_mode == OUT_SUBCODE);
   c_series: cover property (byte_ready && first_hold ##[1:1000] pend == 2'h0);
   c_flags: cover property (out_mode == OUT_FLAGS && !absent);
   c_absent: cover property ($rose(absent));
endmodule : channel_status_subcode_decoder

/* design/serial_word_sender.sv */
// Ten-bit serial word sender with its own burst clock.
// Assumes start is a one-cycle pulse given only while busy is low.
`timescale 1ns/10ps
`include "subcode_defines.svh"
module serial_word_sender (
   input wire logic core_clk,
   input wire logic rst_n,
   word_link_if.sender wl
);
   import subcode_pkg::*;
   sender_state_type state, next_state;
   logic [9:0] shreg, next_shreg;
   logic [3:0] half_cnt, next_half_cnt;
   logic [3:0] bits_left, next_bits_left;
   logic sclk, next_sclk;
   logic sdata, next_sdata;
   logic [3:0] pulses;

   // Burst sequencer: after the first bit, data moves only when the clock falls
   always_comb begin
      next_state = state;
      next_shreg = shreg;
      next_half_cnt = half_cnt;
      next_bits_left = bits_left;
      next_sclk = sclk;
      next_sdata = sdata;
      case (state)
         SND_IDLE: begin
            if (wl.start) begin
               next_state = SND_RUN;
               next_shreg = wl.word;
               next_sdata = wl.word[9]; // First bit set up while clock is low
               next_sclk = 1'b0;
               next_half_cnt = 4'h0;
               next_bits_left = `WORD_BITS;
            end
         end
         SND_RUN: begin
            next_half_cnt = half_cnt + 4'h1;
            if (half_cnt == `UCLK_HALF - 4'h1) begin
               next_half_cnt = 4'h0;
               if (!sclk) begin
                  next_sclk = 1'b1;
               end else begin
                  next_sclk = 1'b0;
                  next_bits_left = bits_left - 4'h1; // Ten pulses per word
                  if (bits_left == 4'h1) begin
                     next_state = SND_IDLE;
                  end else begin
                     next_sdata = shreg[8]; // Change on falling edge
                     next_shreg = {shreg[8:0], 1'b0};
                  end
               end
            end
         end
         default: begin
            next_state = SND_IDLE;
         end
      endcase
   end

   // State registers
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state <= SND_IDLE;
         shreg <= 10'h000;
         half_cnt <= 4'h0;
         bits_left <= 4'h0;
         sclk <= 1'b0;
         sdata <= 1'b0;
      end else begin
         state <= next_state;
         shreg <= next_shreg;
         half_cnt <= next_half_cnt;
         bits_left <= next_bits_left;
         sclk <= next_sclk;
         sdata <= next_sdata;
      end
   end

   assign wl.busy = (state != SND_IDLE);
   assign wl.sclk = sclk;
   assign wl.sdata = sdata;

   // Helper: rising clock edges seen in the current burst
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pulses <= 4'h0;
      end else if (wl.start) begin
         pulses <= 4'h0;
      end else if (next_sclk && !sclk) begin
         pulses <= pulses + 4'h1;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   property p_ten_pulses;
      (state == SND_RUN) && (next_state == SND_IDLE) |=> pulses == 4'ha;
   endproperty
   a_ten_pulses: assert property (p_ten_pulses) else $error("burst did not hold ten pulses");

   property p_data_on_fall;
      (state == SND_RUN) && ($past(state) == SND_RUN) && $changed(sdata) |-> $fell(sclk);
   endproperty
   a_data_on_fall: assert property (p_data_on_fall) else $error("data moved off the falling edge");

   c_burst: cover property (wl.start ##1 wl.busy[*8]);
endmodule : serial_word_sender

/* shared/subcode_defines.svh */
// Offsets-free constant set for the channel-status and subcode decoder.
// Assumes inclusion by bare name; holds definitions only.
`ifndef SUBCODE_DEFINES_SVH
`define SUBCODE_DEFINES_SVH

// Channel-status field values
`define CAT_CD 8'h80
`define MODE_ZERO 2'h0
`define CTL_TWO_CH 2'h0
// Channel-status bit positions, numbered from 1 as received
`define CS_COPY_BIT 3
`define CS_PRE_BIT 4
`define CS_LAST_BIT 5'h10
// Subcode framing
`define ZERO_RUN_MIN 5'h10
`define SUB_BITS 3'h7
`define WORD_BITS 4'ha
`define SERIES_FIRST 2'h3
`define Q_DATA_BITS 7'h50
`define Q_TOTAL_BITS 7'h60
`define CRC_POLY 16'h1021
// Timing counts in core clocks
`define UCLK_HALF 4'h8
`define ABSENT_CLKS 6'h20
`define CDB_HOLD_CLKS 8'h20
`define CDB_TOTAL_CLKS 8'h80

`endif

/* shared/subcode_pkg.sv */
// Types shared by the decoder and its serial word sender.
// Assumes nothing beyond a SystemVerilog compiler.
package subcode_pkg;
   typedef logic [9:0] word_type;
   typedef enum logic [2:0] {OUT_SILENT = 3'b001, OUT_SUBCODE = 3'b010, OUT_FLAGS = 3'b100} out_mode_type;
   typedef enum logic [1:0] {SND_IDLE = 2'b01, SND_RUN = 2'b10} sender_state_type;
endpackage : subcode_pkg

/* shared/word_link_if.sv */
// Link between the decoder and the serial word sender.
// Assumes both ends run on core_clk.
`timescale 1ns/10ps
interface word_link_if;
   import subcode_pkg::*;
   logic start;
   word_type word;
   logic busy;
   logic sclk;
   logic sdata;
   modport source (output start, output word, input busy, input sclk, input sdata);
   modport sender (input start, input word, output busy, output sclk, output sdata);
endinterface : word_link_if

/* tb/subcode_reader_model.sv */
// Far-side reader of the subcode pins: shifts in ten-bit words.
// Assumes the bench raises listen only while the subcode mode is active.
`timescale 1ns/10ps
module subcode_reader_model (
   input wire logic user_data_out,
   input wire logic user_clock_out,
   input wire logic listen,
   output logic [9:0] last_word,
   output int word_count,
   output int glitches
);
   logic [9:0] shift;
   int nbits;

   initial begin
      shift = 10'h000;
      last_word = 10'h000;
      nbits = 0;
      word_count = 0;
      glitches = 0;
   end

   // Sample on the rise, the sender moves data after each fall
   always @(posedge user_clock_out) begin
      if (listen) begin
         shift = {shift[8:0], user_data_out};
         nbits = nbits + 1;
         if (nbits == 10) begin
            last_word = shift;
            word_count = word_count + 1;
            nbits = 0;
         end
      end
   end

   // Drop a half word when listening stops
   always @(negedge listen) begin
      nbits = 0;
   end

   // Delay lets a same-step clock fall land before judging
   always @(user_data_out) begin
      #1;
      if (listen && user_clock_out) begin
         glitches = glitches + 1;
      end
   end
endmodule : subcode_reader_model

/* tb/test_channel_status_subcode_decoder.sv */
// Self-checking bench for the channel-status and subcode decoder.
// Assumes the design and the reader model are compiled before it.
`timescale 1ns/10ps
module test_channel_status_subcode_decoder;
   logic core_clk, rst_n, biphase_in, line_on, listen;
   logic word_strobe, word_left, block_start, word_v, word_u, word_c, word_p;
   logic user_data_out, user_clock_out, preemphasis_level_out, control_bits_out;
   logic [9:0] last_word;
   int word_count, glitches, n_errors, checked;

   channel_status_subcode_decoder channel_status_subcode_decoder_inst (
      .core_clk(core_clk), .rst_n(rst_n), .biphase_in(biphase_in), .word_strobe(word_strobe),
      .word_left(word_left), .block_start(block_start), .word_v(word_v), .word_u(word_u),
      .word_c(word_c), .word_p(word_p), .user_data_out(user_data_out), .user_clock_out(user_clock_out),
      .preemphasis_level_out(preemphasis_level_out), .control_bits_out(control_bits_out));

   subcode_reader_model subcode_reader_model_inst (
      .user_data_out(user_data_out), .user_clock_out(user_clock_out), .listen(listen),
      .last_word(last_word), .word_count(word_count), .glitches(glitches));

   // Core clock, 50 ns
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   // Line activity at the link rate, off phase from the core clock
   initial begin
      biphase_in = 1'b0;
      #13;
      forever #200 biphase_in = line_on ? ~biphase_in : biphase_in;
   end

   task automatic close_out();
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : close_out

   task automatic check(input string what, input logic [9:0] exp, input logic [9:0] seen);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic send_word(input logic left, input logic first, input logic [3:0] vucp);
      @(negedge core_clk);
      word_strobe = 1'b1;
      word_left = left;
      block_start = first;
      {word_v, word_u, word_c, word_p} = vucp;
      @(negedge core_clk);
      word_strobe = 1'b0;
   endtask : send_word

   // Sixteen left words, bit 1 first; user bits all zero
   task automatic cs_block(input logic [16:1] cs);
      for (int n = 1; n <= 16; n++) begin
         send_word(1'b1, n == 1, {2'b00, cs[n], 1'b0});
      end
   endtask : cs_block

   task automatic zero_run();
      repeat (16) send_word(1'b0, 1'b0, 4'h0);
   endtask : zero_run

   // Start bit, then Q first through W
   task automatic send_byte(input logic [6:0] b);
      send_word(1'b0, 1'b0, 4'h4);
      for (int i = 0; i < 7; i++) begin
         send_word(1'b0, 1'b0, {1'b0, b[i], 2'b00});
      end
   endtask : send_byte

   task automatic wait_words(input int target);
      int k;
      k = 0;
      while (word_count < target && k < 600) begin
         @(negedge core_clk);
         k++;
      end
      if (word_count < target) begin
         n_errors++;
         $display("mismatch word count expected %0d seen %0d", target, word_count);
         close_out();
      end
   endtask : wait_words

   // Expected words, b[0] is Q and b[6] is W, sent MSB first
   function automatic logic [9:0] layout(input int s, input logic [6:0] b, input logic crc);
      case (s)
         1: layout = {2'b00, b[4:0], 1'b1, 2'b00};
         2: layout = {crc, 1'b0, b[5:0], 1'b1, 1'b0};
         default: layout = {2'b00, b[6:0], 1'b1};
      endcase
   endfunction : layout

   // Sends a byte and checks each word, then that no stray word follows
   task automatic series(input logic [6:0] b, input int first_s, input logic crc);
      int base;
      base = word_count;
      send_byte(b);
      for (int s = first_s; s <= 3; s++) begin
         wait_words(base + s - first_s + 1);
         check("subcode word", layout(s, b, crc), last_word);
      end
      repeat (200) @(negedge core_clk);
      check("word total", 10'(4 - first_s), 10'(word_count - base));
   endtask : series

   initial begin
      rst_n = 1'b0;
      line_on = 1'b1;
      listen = 1'b0;
      {word_strobe, word_left, block_start, word_v, word_u, word_c, word_p} = 7'h00;
      n_errors = 0;
      checked = 0;
      repeat (3) @(negedge core_clk);
      check("reset outputs", 10'h000, 10'({user_data_out, user_clock_out, preemphasis_level_out, control_bits_out}));
      rst_n = 1'b1;
      // Control bits 1,0,1,0 each held 32 cycles, then low
      send_word(1'b0, 1'b0, 4'hA);
      // V reaches the pin one edge after the strobe is taken
      repeat (1) @(negedge core_clk);
      for (int k = 0; k < 4; k++) begin
         check("control bit start", 10'({1'b1, k[0]} == 2'b10), 10'(control_bits_out));
         repeat (31) @(negedge core_clk);
         check("control bit end", 10'({1'b1, k[0]} == 2'b10), 10'(control_bits_out));
         @(negedge core_clk);
      end
      check("control bits idle", 10'h000, 10'(control_bits_out));
      // Compact disc category, mode 0: subcode on the user pins
      cs_block(16'h0100);
      listen = 1'b1;
      series(7'b0101101, 1, 1'b0);
      series(7'b1010010, 3, 1'b0);
      // Full frame: 80 zero Q bits then the inverted CRC of zeros
      zero_run();
      for (int i = 0; i < 96; i++) begin
         send_byte({6'h00, i >= 80});
      end
      repeat (400) @(negedge core_clk);
      zero_run();
      series(7'b0110011, 1, 1'b1);
      check("data moved while clock high", 10'h000, 10'(glitches));
      listen = 1'b0;
      // Not two-channel: user pins and level stay low
      cs_block(16'h000D);
      repeat (2) @(negedge core_clk);
      check("flags off", 10'h000, 10'({user_data_out, user_clock_out, preemphasis_level_out}));
      cs_block(16'h000C);
      repeat (2) @(negedge core_clk);
      check("flags on", 10'h007, 10'({user_data_out, user_clock_out, preemphasis_level_out}));
      // Copy set, pre-emphasis clear: a swapped pin pair shows here
      cs_block(16'h0004);
      repeat (2) @(negedge core_clk);
      check("copy flag only", 10'h002, 10'({user_data_out, user_clock_out, preemphasis_level_out}));
      // Line goes quiet with control bits high
      send_word(1'b0, 1'b0, 4'hF);
      line_on = 1'b0;
      repeat (40) @(negedge core_clk);
      check("absent levels", 10'h004,
            10'({user_data_out, user_clock_out, preemphasis_level_out, control_bits_out}));
      close_out();
   end
endmodule : test_channel_status_subcode_decoder
